// ==== rtl/tccct_timer.v ====
// Three channel capture/compare timer with APB register access
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "tccct_defines.vh"
module tccct_timer #(
    parameter CW = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [2:0]  chan_in,
    output reg  [2:0]  chan_out,
    output reg  [2:0]  chan_oe_n,
    output reg         timer_irq,
    output reg         shared_timer_irq_flag,
    output reg         chan0_dma_trigger,
    output reg         chan1_dma_trigger,
    output reg         chan2_dma_trigger
);

    // ****************************************
    // Registers
    // ****************************************
    reg  [CW-1:0] count;
    reg           count_down;
    reg  [1:0]    count_mode_select;
    reg  [1:0]    prescaler_select;
    reg  [2:0]    global_tick_divider;
    reg           overflow_flag;
    reg  [2:0]    chan_irq_flag;
    reg           overflow_mask;
    reg           timer_irq_enable;
    reg  [7:0]    chctl [0:2];
    reg  [CW-1:0] channel_compare_value [0:2];
    reg  [CW-1:0] pend_value [0:2];
    reg  [2:0]    pend_valid;
    reg  [7:0]    channel_compare_low_byte [0:2];
    reg  [7:0]    counter_high_latch;
    reg  [7:0]    tick_cnt;
    reg  [7:0]    pre_cnt;
    reg  [2:0]    sync1;
    reg  [2:0]    sync2;
    reg  [2:0]    sync3;
    reg           prev_req;

    wire [7:0]    addr  = {paddr[9:2]};
    wire          wr    = psel & penable & pwrite & pready;
    wire [7:0]    wbyte = pwdata[7:0];
    wire          running = (count_mode_select != `TCCCT_MODE_SUSPEND);
    wire [CW-1:0] period = channel_compare_value[0];
    integer       i;
    integer       k;

    function [7:0] div_count;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    div_count = `TCCCT_DIV1;
                2'h1:    div_count = `TCCCT_DIV8;
                2'h2:    div_count = `TCCCT_DIV32;
                default: div_count = `TCCCT_DIV128;
            endcase
        end
    endfunction

    function is_cc_addr;
        input [7:0] a;
        begin
            is_cc_addr = (a >= `TCCCT_CC0_LOW_IDX) && (a <= `TCCCT_CC2_HIGH_IDX);
        end
    endfunction

    // ****************************************
    // Tick divider and prescaler
    // ****************************************
    wire [7:0] tick_max = (8'h01 << global_tick_divider) - 8'h01;
    wire       tick     = (tick_cnt == tick_max);
    wire       active   = running & tick & (pre_cnt == div_count(prescaler_select) - 8'h01);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 8'h00;
            pre_cnt  <= 8'h00;
        end else begin
            tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
            if (tick) begin
                if (pre_cnt >= div_count(prescaler_select) - 8'h01)
                    pre_cnt <= 8'h00;
                else
                    pre_cnt <= pre_cnt + 8'h01;
            end
        end
    end

    // ****************************************
    // Counter next value and events
    // ****************************************
    reg  [CW-1:0] next_count;
    reg           next_down;
    reg           ovf_evt;
    always @* begin
        next_count = count;
        next_down  = count_down;
        ovf_evt    = 1'b0;
        if (active) begin
            case (count_mode_select)
                `TCCCT_MODE_FREE: begin
                    next_count = count + 16'h0001;
                    ovf_evt    = (count == 16'hFFFF);
                end
                `TCCCT_MODE_MODULO: begin
                    if (count == period) begin
                        next_count = `TCCCT_ZERO16;
                        ovf_evt    = 1'b1;
                    end else
                        next_count = count + 16'h0001;
                end
                `TCCCT_MODE_UPDOWN: begin
                    if (!count_down && count >= period && count != `TCCCT_ZERO16) begin
                        next_down  = 1'b1;
                        next_count = count - 16'h0001;
                    end else if (count_down && count == 16'h0001) begin
                        next_down  = 1'b0;
                        next_count = `TCCCT_ZERO16;
                        ovf_evt    = 1'b1;
                    end else if (count_down)
                        next_count = count - 16'h0001;
                    else
                        next_count = count + 16'h0001;
                end
                default: next_count = count;
            endcase
        end
    end

    wire at_zero = active && (next_count == `TCCCT_ZERO16);

    // ****************************************
    // Capture edges and compare matches
    // ****************************************
    reg [2:0] cap_evt;
    reg [2:0] cmp_evt;
    always @* begin
        for (k = 0; k < 3; k = k + 1) begin
            cap_evt[k] = running && !chctl[k][`TCCCT_CH_CMPMODE_BIT] &&
                ((chctl[k][1:0] == 2'h1 && sync2[k] && !sync3[k]) ||
                 (chctl[k][1:0] == 2'h2 && !sync2[k] && sync3[k]) ||
                 (chctl[k][1:0] == 2'h3 && sync2[k] != sync3[k]));
            cmp_evt[k] = active && chctl[k][`TCCCT_CH_CMPMODE_BIT] &&
                (count == channel_compare_value[k]);
        end
    end

    // Channel 0 flag follows zero in up/down mode
    wire ch0_evt = (count_mode_select == `TCCCT_MODE_UPDOWN) ?
        (at_zero && chctl[0][`TCCCT_CH_CMPMODE_BIT]) || cap_evt[0] :
        (cmp_evt[0] || cap_evt[0]);
    wire [2:0] ch_evt = {cmp_evt[2] | cap_evt[2], cmp_evt[1] | cap_evt[1], ch0_evt};

    wire [2:0] ch_im  = {chctl[2][`TCCCT_CH_IM_BIT], chctl[1][`TCCCT_CH_IM_BIT],
                         chctl[0][`TCCCT_CH_IM_BIT]};
    wire       req_lvl = timer_irq_enable &
        ((overflow_flag & overflow_mask) | |(chan_irq_flag & ch_im));

    // ****************************************
    // Main sequential logic
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count                 <= `TCCCT_ZERO16;
            count_down            <= 1'b0;
            count_mode_select     <= `TCCCT_MODE_SUSPEND;
            prescaler_select      <= 2'h0;
            global_tick_divider   <= 3'h0;
            overflow_flag         <= 1'b0;
            chan_irq_flag         <= 3'h0;
            overflow_mask         <= 1'b1;
            timer_irq_enable      <= 1'b0;
            counter_high_latch    <= 8'h00;
            pend_valid            <= 3'h0;
            sync1                 <= 3'h0;
            sync2                 <= 3'h0;
            sync3                 <= 3'h0;
            chan_out              <= 3'h0;
            chan_oe_n             <= 3'h7;
            timer_irq             <= 1'b0;
            prev_req              <= 1'b0;
            shared_timer_irq_flag <= 1'b0;
            chan0_dma_trigger     <= 1'b0;
            chan1_dma_trigger     <= 1'b0;
            chan2_dma_trigger     <= 1'b0;
            prdata                <= 32'h00000000;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            for (i = 0; i < 3; i = i + 1) begin
                chctl[i]                    <= `TCCCT_CHCTL_RESET;
                channel_compare_value[i]    <= `TCCCT_ZERO16;
                pend_value[i]               <= `TCCCT_ZERO16;
                channel_compare_low_byte[i] <= 8'h00;
            end
        end else begin
            sync1 <= chan_in;
            sync2 <= sync1;
            sync3 <= sync2;
            // APB: one wait state, answer in the second access cycle
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel & penable & ~pready & ~(is_cc_addr(addr) ||
                (addr >= `TCCCT_CNT_LOW_IDX && addr <= `TCCCT_CHCTL2_IDX) ||
                addr == `TCCCT_IRQCFG_IDX))
                pslverr <= 1'b1;
            // Counter
            if (wr && addr == `TCCCT_CNT_LOW_IDX) begin
                count      <= `TCCCT_ZERO16;
                count_down <= 1'b0;
            end else begin
                count      <= next_count;
                count_down <= next_down;
            end
            // Flags: hardware set wins over software clear
            overflow_flag <= (overflow_flag & ~(wr && addr == `TCCCT_CTL_IDX &&
                !pwdata[`TCCCT_CTL_OVF_BIT])) | ovf_evt;
            chan_irq_flag <= (chan_irq_flag & ~({3{wr && addr == `TCCCT_CTL_IDX}} &
                ~pwdata[7:5])) | ch_evt;
            if (ovf_evt || |ch_evt)
                shared_timer_irq_flag <= 1'b1;
            else if (wr && addr == `TCCCT_IRQCFG_IDX && !pwdata[7])
                shared_timer_irq_flag <= 1'b0;
            // New request only on rising request level
            prev_req  <= req_lvl;
            timer_irq <= req_lvl & ~prev_req;
            chan0_dma_trigger <= cmp_evt[0];
            chan1_dma_trigger <= cmp_evt[1];
            chan2_dma_trigger <= cmp_evt[2];
            // Channels
            for (i = 0; i < 3; i = i + 1) begin
                chan_oe_n[i] <= ~chctl[i][`TCCCT_CH_CMPMODE_BIT];
                if (cap_evt[i])
                    channel_compare_value[i] <= count;
                else if (pend_valid[i] && (chctl[i][5:3] < `TCCCT_ACT_SET_UP || at_zero))
                begin
                    channel_compare_value[i] <= pend_value[i];
                    pend_valid[i] <= 1'b0;
                end
                if (cmp_evt[i]) begin
                    case (chctl[i][5:3])
                        `TCCCT_ACT_SET:    chan_out[i] <= 1'b1;
                        `TCCCT_ACT_CLEAR:  chan_out[i] <= 1'b0;
                        `TCCCT_ACT_TOGGLE: chan_out[i] <= ~chan_out[i];
                        `TCCCT_ACT_SET_UP: chan_out[i] <= ~count_down;
                        `TCCCT_ACT_CLR_UP: chan_out[i] <= count_down;
                        default:           chan_out[i] <= chan_out[i];
                    endcase
                end else if (at_zero && chctl[i][`TCCCT_CH_CMPMODE_BIT] &&
                    count_mode_select != `TCCCT_MODE_UPDOWN) begin
                    if (chctl[i][5:3] == `TCCCT_ACT_SET_UP)
                        chan_out[i] <= 1'b0;
                    else if (chctl[i][5:3] == `TCCCT_ACT_CLR_UP)
                        chan_out[i] <= 1'b1;
                end
            end
            // Register writes
            if (wr) begin
                case (addr)
                    `TCCCT_CTL_IDX: begin
                        count_mode_select <= wbyte[1:0];
                        prescaler_select  <= wbyte[3:2];
                    end
                    `TCCCT_CHCTL0_IDX: chctl[0] <= {1'b0, wbyte[6], 1'b0, wbyte[4:0]};
                    `TCCCT_CHCTL1_IDX: chctl[1] <= {1'b0, wbyte[6:0]};
                    `TCCCT_CHCTL2_IDX: chctl[2] <= {1'b0, wbyte[6:0]};
                    `TCCCT_IRQCFG_IDX: begin
                        overflow_mask       <= wbyte[`TCCCT_IRQ_OVFIM_BIT];
                        timer_irq_enable    <= wbyte[`TCCCT_IRQ_EN_BIT];
                        global_tick_divider <= wbyte[4:2];
                    end
                    default: begin
                        for (i = 0; i < 3; i = i + 1) begin
                            if (addr == `TCCCT_CC0_LOW_IDX + 2 * i)
                                channel_compare_low_byte[i] <= wbyte;
                            if (addr == `TCCCT_CC0_HIGH_IDX + 2 * i) begin
                                pend_value[i] <= {wbyte, channel_compare_low_byte[i]};
                                pend_valid[i] <= 1'b1;
                            end
                        end
                    end
                endcase
            end
            // Register reads
            if (psel & penable & ~pwrite & ~pready) begin
                prdata <= 32'h00000000;
                case (addr)
                    `TCCCT_CNT_LOW_IDX:  prdata[7:0] <= count[7:0];
                    `TCCCT_CNT_HIGH_IDX: prdata[7:0] <= counter_high_latch;
                    `TCCCT_CTL_IDX:      prdata[7:0] <= {chan_irq_flag, overflow_flag,
                                                         prescaler_select, count_mode_select};
                    `TCCCT_CHCTL0_IDX:   prdata[7:0] <= chctl[0];
                    `TCCCT_CHCTL1_IDX:   prdata[7:0] <= chctl[1];
                    `TCCCT_CHCTL2_IDX:   prdata[7:0] <= chctl[2];
                    `TCCCT_IRQCFG_IDX:   prdata[7:0] <= {shared_timer_irq_flag, 2'h0,
                        global_tick_divider, timer_irq_enable, overflow_mask};
                    `TCCCT_CC0_LOW_IDX:  prdata[7:0] <= channel_compare_value[0][7:0];
                    `TCCCT_CC0_HIGH_IDX: prdata[7:0] <= channel_compare_value[0][15:8];
                    `TCCCT_CC1_LOW_IDX:  prdata[7:0] <= channel_compare_value[1][7:0];
                    `TCCCT_CC1_HIGH_IDX: prdata[7:0] <= channel_compare_value[1][15:8];
                    `TCCCT_CC2_LOW_IDX:  prdata[7:0] <= channel_compare_value[2][7:0];
                    `TCCCT_CC2_HIGH_IDX: prdata[7:0] <= channel_compare_value[2][15:8];
                    default:             prdata[7:0] <= 8'h00;
                endcase
                if (addr == `TCCCT_CNT_LOW_IDX)
                    counter_high_latch <= count[15:8];
            end
        end
    end

endmodule // tccct_timer

// ==== shared/tccct_defines.vh ====
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TCCCT_DEFINES_VH
`define TCCCT_DEFINES_VH
// Register indices; the byte address on the bus is the index times four
`define TCCCT_CNT_LOW_IDX        8'hE2
`define TCCCT_CNT_HIGH_IDX       8'hE3
`define TCCCT_CTL_IDX            8'hE4
`define TCCCT_CHCTL0_IDX         8'hE5
`define TCCCT_CHCTL1_IDX         8'hE6
`define TCCCT_CHCTL2_IDX         8'hE7
`define TCCCT_CC0_LOW_IDX        8'hD0
`define TCCCT_CC0_HIGH_IDX       8'hD1
`define TCCCT_CC1_LOW_IDX        8'hD2
`define TCCCT_CC1_HIGH_IDX       8'hD3
`define TCCCT_CC2_LOW_IDX        8'hD4
`define TCCCT_CC2_HIGH_IDX       8'hD5
`define TCCCT_IRQCFG_IDX         8'hD8
// Control register fields
`define TCCCT_CTL_MODE_LSB       0
`define TCCCT_CTL_DIV_LSB        2
`define TCCCT_CTL_OVF_BIT        4
`define TCCCT_CTL_CH0IF_BIT      5
// Channel control fields
`define TCCCT_CH_CAP_LSB         0
`define TCCCT_CH_CMPMODE_BIT     2
`define TCCCT_CH_ACT_LSB         3
`define TCCCT_CH_IM_BIT          6
`define TCCCT_CHCTL_RESET        8'h40
// Interrupt configuration fields
`define TCCCT_IRQ_OVFIM_BIT      0
`define TCCCT_IRQ_EN_BIT         1
`define TCCCT_IRQ_TICK_LSB       2
`define TCCCT_IRQCFG_RESET       8'h01
// Count modes
`define TCCCT_MODE_SUSPEND       2'h0
`define TCCCT_MODE_FREE          2'h1
`define TCCCT_MODE_MODULO        2'h2
`define TCCCT_MODE_UPDOWN        2'h3
// Compare actions
`define TCCCT_ACT_SET            3'h0
`define TCCCT_ACT_CLEAR          3'h1
`define TCCCT_ACT_TOGGLE         3'h2
`define TCCCT_ACT_SET_UP         3'h3
`define TCCCT_ACT_CLR_UP         3'h4
// Prescaler division counts
`define TCCCT_DIV1               8'd1
`define TCCCT_DIV8               8'd8
`define TCCCT_DIV32              8'd32
`define TCCCT_DIV128             8'd128
`define TCCCT_ZERO16             16'h0000
`endif

// ==== testbench/tccct_timer_props.sv ====
// Port-level checks of the capture/compare timer
`timescale 1ns/100ps
module tccct_timer_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  chan_oe_n,
    input wire logic        timer_irq,
    input wire logic        shared_timer_irq_flag,
    input wire logic        chan0_dma_trigger,
    input wire logic        chan1_dma_trigger
);
// ****
// Properties
// ****
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
sequence s_access;
    psel && penable && !pready;
endsequence
sequence s_answer;
    pready ##1 !pready;
endsequence
property p_ready_wait;
    s_access |=> s_answer;
endproperty
a_ready_wait: assert property (p_ready_wait) else $error("ready not one pulse after access");
property p_err_ready;
    pslverr |-> pready;
endproperty
a_err_ready: assert property (p_err_ready) else $error("error without ready");
property p_rdata_zero;
    pready && !pwrite |-> prdata[31:8] == 24'h000000;
endproperty
a_rdata_zero: assert property (p_rdata_zero) else $error("read data upper bits set");
property p_irq_pulse;
    timer_irq |=> !timer_irq;
endproperty
a_irq_pulse: assert property (p_irq_pulse) else $error("request longer than one cycle");
property p_irq_flag;
    timer_irq |-> shared_timer_irq_flag;
endproperty
a_irq_flag: assert property (p_irq_flag) else $error("request without timer flag");
property p_dma0_pulse;
    chan0_dma_trigger |=> !chan0_dma_trigger;
endproperty
a_dma0_pulse: assert property (p_dma0_pulse) else $error("trigger longer than a pulse");
property p_dma_flag;
    chan1_dma_trigger |-> ##[0:2] shared_timer_irq_flag;
endproperty
a_dma_flag: assert property (p_dma_flag) else $error("compare without timer flag");
property p_oe_by_write;
    !$stable(chan_oe_n) |-> $past(psel && pwrite && pready, 2);
endproperty
a_oe_by_write: assert property (p_oe_by_write) else $error("pin direction moved alone");
endmodule // tccct_timer_props
bind tccct_timer tccct_timer_props u_tccct_timer_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_oe_n(chan_oe_n), .timer_irq(timer_irq),
    .shared_timer_irq_flag(shared_timer_irq_flag),
    .chan0_dma_trigger(chan0_dma_trigger), .chan1_dma_trigger(chan1_dma_trigger));

// ==== testbench/tccct_pin_model.sv ====
// External pin sources and loads on the three channels
`timescale 1ns/100ps
module tccct_pin_model (
    input  wire logic       pclk,
    input  wire logic [2:0] chan_out,
    input  wire logic [2:0] chan_oe_n,
    output wire logic [2:0] chan_in
);
// ****
// Pin levels
// ****
logic [2:0] drv = 3'h0;
assign chan_in = (~chan_oe_n & chan_out) | (chan_oe_n & drv);
// New source level, held three clocks
task automatic drive(input int ch, input logic lvl);
    @(posedge pclk);
    drv[ch] <= lvl;
    repeat (3) @(posedge pclk);
endtask
endmodule // tccct_pin_model

// ==== testbench/tccct_timer_tb_top.sv ====
// Self-checking bench for the capture/compare timer
`timescale 1ns/100ps
module tccct_timer_tb_top;
// ****
// Stimulus and checks
// ****
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
logic [9:0] paddr = 0;
logic [31:0] pwdata = 0;
wire [31:0] prdata;
wire pready, pslverr, timer_irq, shared_timer_irq_flag;
wire [2:0] chan_in, chan_out, chan_oe_n;
wire chan0_dma_trigger, chan1_dma_trigger, chan2_dma_trigger;
int failures = 0, checks_done = 0, irqs = 0, dma0s = 0, dma1s = 0, dma2s = 0, tog1 = 0, m;
logic [7:0] rdv;
logic last_err, o1p = 0;
always #5 pclk = ~pclk;
always @(posedge pclk) begin
    o1p <= chan_out[1];
    if (chan_out[1] !== o1p) tog1++;
    if (timer_irq === 1'h1) irqs++;
    if (chan0_dma_trigger === 1'h1) dma0s++;
    if (chan1_dma_trigger === 1'h1) dma1s++;
    if (chan2_dma_trigger === 1'h1) dma2s++;
end
tccct_timer u_tccct_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_in(chan_in), .chan_out(chan_out), .chan_oe_n(chan_oe_n),
    .timer_irq(timer_irq), .shared_timer_irq_flag(shared_timer_irq_flag),
    .chan0_dma_trigger(chan0_dma_trigger), .chan1_dma_trigger(chan1_dma_trigger),
    .chan2_dma_trigger(chan2_dma_trigger));
tccct_pin_model u_tccct_pin_model (.pclk(pclk), .chan_out(chan_out),
    .chan_oe_n(chan_oe_n), .chan_in(chan_in));
task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
        failures++;
        $display("BAD %0t byte %h want %h", $time, got, exp);
    end
endtask
task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
        failures++;
        $display("BAD %0t bit %b want %b", $time, got, exp);
    end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
        @(posedge pclk);
    end
    rdv = prdata[7:0];
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1, a, d);
endtask
task automatic rd(input logic [7:0] a);
    apb(0, a, 8'h00);
endtask
task automatic t_reset;
    rd(8'hE3); chk8(rdv, 8'h00);
    rd(8'hE4); chk8(rdv, 8'h00);
    rd(8'hE5); chk8(rdv, 8'h40);
    rd(8'hD8); chk8(rdv, 8'h01);
    chk1(chan_oe_n[0], 1'h1);
    rd(8'h10); chk8(rdv, 8'h00);
    chk1(last_err, 1'h1);
endtask
task automatic t_modulo;
    wr(8'hD0, 8'h05); wr(8'hD1, 8'h00); wr(8'hE5, 8'h44);
    wr(8'hE2, 8'h00); wr(8'hE4, 8'h02);
    repeat (20) @(posedge pclk);
    rd(8'hE4); chk1(rdv[4], 1'h1);
    chk1(shared_timer_irq_flag, 1'h1);
    chk1(irqs == 0, 1'h1);
    wr(8'hD8, 8'h83);
    repeat (3) @(posedge pclk);
    chk1(irqs == 1, 1'h1);
    repeat (20) @(posedge pclk);
    chk1(irqs == 1, 1'h1);
    repeat (4) begin
        rd(8'hE2); chk1(rdv <= 8'h05, 1'h1);
    end
    chk1(dma0s > 1, 1'h1);
    wr(8'hE4, 8'h00);
endtask
task automatic t_latch;
    wr(8'hD0, 8'h00); wr(8'hD1, 8'h02); wr(8'hE2, 8'h00); wr(8'hE4, 8'h02);
    repeat (300) @(posedge pclk);
    wr(8'hE4, 8'h00);
    rd(8'hE2); rd(8'hE3); chk8(rdv, 8'h01);
    wr(8'hE2, 8'h00);
    rd(8'hE2); chk8(rdv, 8'h00);
    rd(8'hE3); chk8(rdv, 8'h00);
endtask
task automatic t_updown;
    wr(8'hD0, 8'h40); wr(8'hD1, 8'h00); wr(8'hE4, 8'h03);
    repeat (90) @(posedge pclk);
    rd(8'hE4); chk1(rdv[4], 1'h0);
    chk1(rdv[5], 1'h0);
    repeat (60) @(posedge pclk);
    rd(8'hE4); chk1(rdv[4], 1'h1);
    chk1(rdv[5], 1'h1);
    rd(8'hE2); chk1(rdv <= 8'h40, 1'h1);
    wr(8'hE4, 8'h00);
endtask
task automatic t_compare;
    wr(8'hD0, 8'h0A); wr(8'hD1, 8'h00); wr(8'hD2, 8'h03); wr(8'hD3, 8'h00);
    wr(8'hE6, 8'h44); wr(8'hE2, 8'h00); wr(8'hE4, 8'h02);
    chk1(chan_oe_n[1], 1'h0);
    repeat (15) @(posedge pclk);
    chk1(chan_out[1], 1'h1);
    wr(8'hE6, 8'h4C);
    repeat (15) @(posedge pclk);
    chk1(chan_out[1], 1'h0);
    rd(8'hE4); chk1(rdv[6], 1'h1);
    chk1(dma1s > 1, 1'h1);
    wr(8'hE6, 8'h54);
    m = tog1;
    repeat (30) @(posedge pclk);
    chk1(tog1 - m >= 2, 1'h1);
    wr(8'hD2, 8'h20);
    m = tog1;
    repeat (30) @(posedge pclk);
    chk1(tog1 > m, 1'h1);
    wr(8'hD3, 8'h00);
    m = tog1;
    repeat (30) @(posedge pclk);
    chk1(tog1 == m, 1'h1);
    wr(8'hE4, 8'h00);
endtask
task automatic t_capture;
    wr(8'hE7, 8'h42); wr(8'hE2, 8'h00); wr(8'hE4, 8'h02);
    chk1(chan_oe_n[2], 1'h1);
    u_tccct_pin_model.drive(2, 1'h1);
    rd(8'hE4); chk1(rdv[7], 1'h0);
    u_tccct_pin_model.drive(2, 1'h0);
    rd(8'hE4); chk1(rdv[7], 1'h1);
    rd(8'hD4); chk1(rdv <= 8'h0A, 1'h1);
    rd(8'hD5); chk8(rdv, 8'h00);
    wr(8'hE4, 8'h00);
endtask
task automatic hi_count(input int ch, input int n);
    m = 0;
    repeat (n) begin
        @(posedge pclk);
        m = m + chan_out[ch];
    end
endtask
task automatic t_pwm;
    wr(8'hD4, 8'h04); wr(8'hD5, 8'h00); wr(8'hE7, 8'h5C);
    wr(8'hE2, 8'h00); wr(8'hE4, 8'h02);
    repeat (11) @(posedge pclk);
    hi_count(2, 22); chk1(m == 12, 1'h1);
    chk1(dma2s > 1, 1'h1);
    wr(8'hE4, 8'h00); wr(8'hD2, 8'h04); wr(8'hD3, 8'h00); wr(8'hE6, 8'h64);
    wr(8'hE2, 8'h00); wr(8'hE4, 8'h03);
    repeat (11) @(posedge pclk);
    hi_count(1, 40); chk1(m == 16, 1'h1);
    wr(8'hE4, 8'h00); wr(8'hE2, 8'h00); wr(8'hE4, 8'h06);
    repeat (40) @(posedge pclk);
    rd(8'hE2); chk8(rdv, 8'h05);
    wr(8'hE4, 8'h00);
endtask
task automatic final_report;
    $display("Checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
initial begin
    #200000;
    failures++;
    final_report;
end
initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_modulo;
    t_latch;
    t_updown;
    t_compare;
    t_capture;
    t_pwm;
    final_report;
end
endmodule // tccct_timer_tb_top
